//--- rtl/mrc_lvr_filter.sv
// qualifies the supply-low indication over a minimum duration
`timescale 1ns/1ns
module mrc_lvr_filter #(
  parameter int QUAL_CYCLES = 100000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic low,
  output logic active
);
  logic [31:0] cnt_r;
  wire at_qual = (cnt_r == 32'(QUAL_CYCLES));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 32'h0;
      active <= 1'b0;
    end else begin
      // any high sample restarts the count, so short dips never qualify
      cnt_r <= !low ? 32'h0 : (at_qual ? cnt_r : cnt_r + 32'h1);
      active <= low && enable && at_qual;
    end
  end
endmodule // mrc_lvr_filter

//--- rtl/mrc_pkg.sv
// constants and types shared by the reset controller
package mrc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // low_supply_qualify_time: a low supply lasting no longer than this is ignored
  localparam int LOW_SUPPLY_QUALIFY_TIME_NS = 1000000;
  localparam int LOW_SUPPLY_QUALIFY_CYCLES = LOW_SUPPLY_QUALIFY_TIME_NS / CLK_PERIOD_NS;
  // reset_release_delay after the last cause goes away
  localparam int RESET_RELEASE_DELAY_NS = 1000;
  localparam int RESET_RELEASE_CYCLES =
    (RESET_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RELEASE_LAST = 8'(RESET_RELEASE_CYCLES - 1);
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  // status fields
  localparam int ST_TO_BIT = 0;
  localparam int ST_PDF_BIT = 1;
  localparam int ST_HOLD_BIT = 2;
  localparam int ST_CAUSE_LSB = 4;
  // config fields
  localparam int CF_LVR_EN_BIT = 0;
  localparam int CF_SEL_LSB = 1;
  // reset values and bus response codes
  localparam logic [7:0] PORT_INIT_VALUE = 8'hff;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_POR, CAUSE_LVR, CAUSE_PIN, CAUSE_WDT, CAUSE_WDT_HALT
  } mrc_cause_t;
  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_DELAY} mrc_state_t;
endpackage

//--- rtl/mrc_reset_ctrl.sv
// reset controller: cause arbitration, hold/release sequencing, cause flags
`timescale 1ns/1ns
module mrc_reset_ctrl
  import mrc_pkg::*;
#(
  parameter int QUAL_CYCLES = LOW_SUPPLY_QUALIFY_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_reset_n,
  input wire logic supply_low,
  input wire logic cfg_lvr_en,
  input wire logic [1:0] cfg_lvr_sel,
  input wire logic wdog_timeout,
  input wire logic cpu_halted,
  input wire logic halt_enter,
  output logic core_hold,
  output logic pc_clear,
  output logic sp_to_top,
  output logic sp_clear,
  output logic int_disable,
  output logic wdog_clear,
  output logic timer_off,
  output logic prescaler_clear,
  output logic port_preset,
  output logic [7:0] port_init,
  output logic periph_default,
  output logic ctx_unknown,
  output logic supply_low_reset,
  output logic [1:0] supply_low_threshold,
  output logic [1:0] low_voltage_detect_sel,
  output logic wdog_timeout_flag,
  output logic powerdown_flag
);
  logic pin_n_s, low_s;
  logic [2:0] cfg_s;
  logic [2:0] cfg_r;
  logic por_pend_r, pin_low_q_r, lvr_q_r;
  logic [1:0] por_dly_r;
  mrc_state_t st_r, st_nxt;
  logic [7:0] dly_r;
  mrc_cause_t cause_r, cause_nxt;
  logic to_nxt, pdf_nxt;
  logic aw_have_r, w_have_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_strb0_r;

  mrc_sync #(.W(2), .RESET_VAL(2'b11)) u_sync_pin (
    .aclk(aclk), .aresetn(aresetn),
    .d({ext_reset_n, ~supply_low}), .q({pin_n_s, low_s})
  );
  mrc_sync #(.W(3), .RESET_VAL(CFG_RESET)) u_sync_cfg (
    .aclk(aclk), .aresetn(aresetn),
    .d({cfg_lvr_sel, cfg_lvr_en}), .q(cfg_s)
  );
  mrc_lvr_filter #(.QUAL_CYCLES(QUAL_CYCLES)) u_lvr (
    .aclk(aclk), .aresetn(aresetn),
    .enable(cfg_r[CF_LVR_EN_BIT]), .low(~low_s), .active(supply_low_reset)
  );

  // cause detection and priority
  wire pin_low = ~pin_n_s;
  wire por_trig = por_pend_r;
  wire lvr_trig = supply_low_reset & ~lvr_q_r;
  wire pin_trig = pin_low & ~pin_low_q_r;
  wire wdt_trig = wdog_timeout & (st_r == ST_RUN);
  wire any_trig = por_trig | lvr_trig | pin_trig | wdt_trig;
  wire wdt_win = wdt_trig & ~por_trig & ~lvr_trig & ~pin_trig;
  wire halt_only = wdt_win & cpu_halted;
  wire full_trig = any_trig & ~halt_only;
  wire hold_cond = pin_low | supply_low_reset;
  wire dly_done = (dly_r == RELEASE_LAST);
  // straps need the two synchroniser stages before they can be latched
  wire cfg_load = por_dly_r[1];

  always_comb begin
    cause_nxt = cause_r;
    if (por_trig) begin
      cause_nxt = CAUSE_POR;
    end else if (lvr_trig) begin
      cause_nxt = CAUSE_LVR;
    end else if (pin_trig) begin
      cause_nxt = CAUSE_PIN;
    end else if (wdt_win) begin
      cause_nxt = cpu_halted ? CAUSE_WDT_HALT : CAUSE_WDT;
    end
  end

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_RUN: begin
        if (any_trig) st_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (!hold_cond && !any_trig) st_nxt = ST_DELAY;
      end
      ST_DELAY: begin
        if (hold_cond || any_trig) begin
          st_nxt = ST_HOLD;
        end else if (dly_done) begin
          st_nxt = ST_RUN;
        end
      end
    endcase
  end

  // register bus decode
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire wr_status = wr_fire & (aw_addr_r == ADDR_STATUS);
  wire wr_mapped = wr_status | (aw_addr_r == ADDR_CONFIG);
  wire clr_to = wr_status & w_strb0_r & w_data_r[ST_TO_BIT];
  wire clr_pdf = wr_status & w_strb0_r & w_data_r[ST_PDF_BIT];
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire rd_status = (s_axi_araddr == ADDR_STATUS);
  wire rd_config = (s_axi_araddr == ADDR_CONFIG);
  wire [31:0] status_word = {25'h0, cause_r, 1'b0, core_hold, powerdown_flag, wdog_timeout_flag};
  wire [31:0] config_word = {29'h0, cfg_r};

  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign core_hold = (st_r != ST_RUN);
  assign supply_low_threshold = cfg_r[CF_SEL_LSB +: 2];
  assign low_voltage_detect_sel = cfg_r[CF_SEL_LSB +: 2];

  // cause flags; a hardware set always beats a software clear
  always_comb begin
    to_nxt = wdog_timeout_flag;
    pdf_nxt = powerdown_flag;
    if (clr_to) to_nxt = 1'b0;
    if (clr_pdf) pdf_nxt = 1'b0;
    if (halt_enter) pdf_nxt = 1'b1;
    if (wdt_win) to_nxt = 1'b1;
    if (halt_only) pdf_nxt = 1'b1;
    if (por_trig) begin
      to_nxt = 1'b0;
      pdf_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_pend_r <= 1'b1;
      por_dly_r <= 2'b00;
      st_r <= ST_HOLD;
      cause_r <= CAUSE_NONE;
      dly_r <= 8'h0;
      pin_low_q_r <= 1'b0;
      lvr_q_r <= 1'b0;
      cfg_r <= CFG_RESET;
    end else begin
      por_pend_r <= 1'b0;
      por_dly_r <= {por_dly_r[0], por_pend_r};
      st_r <= st_nxt;
      cause_r <= cause_nxt;
      dly_r <= (st_r == ST_DELAY && !hold_cond) ? dly_r + 8'h1 : 8'h0;
      pin_low_q_r <= pin_low;
      lvr_q_r <= supply_low_reset;
      // options are latched once after power-on and fixed afterward
      if (cfg_load) cfg_r <= cfg_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end else begin
      wdog_timeout_flag <= to_nxt;
      powerdown_flag <= pdf_nxt;
    end
  end

  // per-cause initialisation strobes, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_clear <= 1'b0;
      sp_to_top <= 1'b0;
      sp_clear <= 1'b0;
      int_disable <= 1'b0;
      wdog_clear <= 1'b0;
      timer_off <= 1'b0;
      prescaler_clear <= 1'b0;
      port_preset <= 1'b0;
      periph_default <= 1'b0;
      ctx_unknown <= 1'b0;
      port_init <= PORT_INIT_VALUE;
    end else begin
      pc_clear <= any_trig;
      sp_clear <= halt_only;
      sp_to_top <= full_trig;
      int_disable <= any_trig;
      wdog_clear <= any_trig;
      timer_off <= full_trig;
      prescaler_clear <= full_trig;
      port_preset <= full_trig;
      periph_default <= full_trig;
      ctx_unknown <= por_trig;
      port_init <= PORT_INIT_VALUE;
    end
  end

  // axi4-lite slave: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r <= 8'h0;
      w_strb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_status ? status_word : (rd_config ? config_word : 32'h0);
        s_axi_rresp <= (rd_status || rd_config) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checking helpers: consecutive low samples and quiet held cycles
  logic [31:0] low_run_r;
  logic [15:0] quiet_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_run_r <= 32'h0;
      quiet_r <= 16'h0;
    end else begin
      low_run_r <= low_s ? 32'h0 : low_run_r + 32'h1;
      quiet_r <= (core_hold && !hold_cond && !any_trig) ? quiet_r + 16'h1 : 16'h0;
    end
  end

  sequence s_strobe_then_idle;
    wdog_clear ##1 !wdog_clear;
  endsequence

  property p_pin_restart;
    @(posedge aclk) disable iff (!aresetn)
      (pin_trig && !por_trig && !lvr_trig) |=> pc_clear && core_hold && cause_r == CAUSE_PIN;
  endproperty
  a_pin_restart: assert property (p_pin_restart) else $error("pin reset not applied");

  property p_lvr_qualify;
    @(posedge aclk) disable iff (!aresetn)
      supply_low_reset |-> low_run_r > 32'(QUAL_CYCLES) && cfg_r[CF_LVR_EN_BIT];
  endproperty
  a_lvr_qualify: assert property (p_lvr_qualify) else $error("short supply dip reset");

  property p_option_fixed;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_load |=> $stable(supply_low_threshold) && $stable(cfg_r);
  endproperty
  a_option_fixed: assert property (p_option_fixed) else $error("option changed");

  property p_wdt_running;
    @(posedge aclk) disable iff (!aresetn)
      (wdt_win && !cpu_halted && !halt_enter && !clr_pdf) |=>
        wdog_timeout_flag && port_preset && sp_to_top && $stable(powerdown_flag);
  endproperty
  a_wdt_running: assert property (p_wdt_running) else $error("running watchdog reset");

  property p_wdt_halted;
    @(posedge aclk) disable iff (!aresetn)
      halt_only |=> pc_clear && sp_clear && !port_preset && !timer_off
        && wdog_timeout_flag && powerdown_flag;
  endproperty
  a_wdt_halted: assert property (p_wdt_halted) else $error("halted watchdog reset");

  property p_por_flags;
    @(posedge aclk) disable iff (!aresetn)
      por_trig |=> !wdog_timeout_flag && !powerdown_flag && ctx_unknown;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("flags not cleared");

  property p_flags_kept;
    @(posedge aclk) disable iff (!aresetn)
      ((pin_trig || lvr_trig) && !por_trig && !halt_enter && !clr_to && !clr_pdf) |=>
        $stable(wdog_timeout_flag) && $stable(powerdown_flag);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags disturbed");

  property p_int_wdog;
    @(posedge aclk) disable iff (!aresetn)
      (pc_clear && !any_trig) |-> int_disable and s_strobe_then_idle;
  endproperty
  a_int_wdog: assert property (p_int_wdog) else $error("interrupts or watchdog");

  property p_full_init;
    @(posedge aclk) disable iff (!aresetn)
      sp_to_top |-> timer_off && prescaler_clear && port_preset && periph_default
        && port_init == PORT_INIT_VALUE;
  endproperty
  a_full_init: assert property (p_full_init) else $error("init incomplete");

  property p_release_delay;
    @(posedge aclk) disable iff (!aresetn)
      $fell(core_hold) |-> $past(quiet_r) == 16'(RESET_RELEASE_CYCLES);
  endproperty
  a_release_delay: assert property (p_release_delay) else $error("early release");

  property p_por_wins;
    @(posedge aclk) disable iff (!aresetn)
      por_trig |=> cause_r == CAUSE_POR;
  endproperty
  a_por_wins: assert property (p_por_wins) else $error("cause priority");
endmodule // mrc_reset_ctrl

//--- rtl/mrc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module mrc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // mrc_sync

//--- tb/mcu_reset_controller_bench.sv
// self-checking bench for the reset controller
`timescale 1ns/1ns
module mcu_reset_controller_bench;
  import mrc_pkg::*;
  typedef struct {logic [1:0] kind; logic [8:0] strb; logic [2:0] cause; logic [1:0] flags;} mrc_row_t;
  logic aclk, aresetn, press, sag, wdog_timeout, cpu_halted, halt_enter;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_init;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, thr, lvd;
  logic ext_reset_n, supply_low, core_hold, pc_clear, sp_to_top, sp_clear, int_disable;
  logic wdog_clear, timer_off, prescaler_clear, port_preset, periph_default, ctx_unknown;
  logic supply_low_reset, wdog_timeout_flag, powerdown_flag;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // kinds: 0 pin, 1 low supply, 2 watchdog running, 3 watchdog halted
  mrc_row_t rows [4] = '{
    '{2'd2, 9'h07f, 3'd4, 2'b01},
    '{2'd0, 9'h07f, 3'd3, 2'b01},
    '{2'd3, 9'h083, 3'd5, 2'b11},
    '{2'd1, 9'h07f, 3'd2, 2'b11}};

  mrc_switch_model sw (.press(press), .sag(sag), .ext_reset_n(ext_reset_n),
    .supply_low(supply_low));
  mrc_reset_ctrl #(.QUAL_CYCLES(20)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_reset_n(ext_reset_n),
    .supply_low(supply_low), .cfg_lvr_en(1'b1), .cfg_lvr_sel(2'h2),
    .wdog_timeout(wdog_timeout), .cpu_halted(cpu_halted), .halt_enter(halt_enter),
    .core_hold(core_hold), .pc_clear(pc_clear), .sp_to_top(sp_to_top), .sp_clear(sp_clear),
    .int_disable(int_disable), .wdog_clear(wdog_clear), .timer_off(timer_off),
    .prescaler_clear(prescaler_clear), .port_preset(port_preset), .port_init(port_init),
    .periph_default(periph_default), .ctx_unknown(ctx_unknown),
    .supply_low_reset(supply_low_reset), .supply_low_threshold(thr),
    .low_voltage_detect_sel(lvd), .wdog_timeout_flag(wdog_timeout_flag),
    .powerdown_flag(powerdown_flag));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard: the whole sequence needs under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [8:0] strobes();
    return {ctx_unknown, sp_clear, port_preset, sp_to_top, timer_off, prescaler_clear,
      periph_default, int_disable, wdog_clear};
  endfunction

  // strobes stand one cycle, so they are captured in the cycle of pc_clear
  task automatic wait_strobe(input logic [8:0] exp);
    int n;
    n = 0;
    // a watchdog strobe may already stand in the cycle of the call
    #1;
    while (pc_clear !== 1'b1 && n < 200) begin @(posedge aclk); #1; n++; end
    chk({23'h0, strobes()}, {23'h0, exp});
  endtask

  // a halted watchdog also passes one ST_HOLD cycle before its delay; the check allows two cycles of slack
  task automatic wait_release();
    int n;
    n = 0;
    while (core_hold !== 1'b0 && n < 400) begin @(posedge aclk); #1; n++; end
    chk({31'h0, n >= RESET_RELEASE_CYCLES - 2 && n < 400}, 32'h1);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ta, tw, ga, gw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      #1;
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      ta = ta || ga;
      tw = tw || gw;
    end
    do begin #1; ga = s_axi_bvalid; resp = s_axi_bresp; @(posedge aclk); end while (!ga);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic g;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin #1; g = s_axi_arready; @(posedge aclk); end while (!g);
    s_axi_arvalid <= 1'b0;
    do begin #1; g = s_axi_rvalid; d = s_axi_rdata; resp = s_axi_rresp; @(posedge aclk); end
      while (!g);
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] resp;
    logic hit;
    {press, sag, wdog_timeout, cpu_halted, halt_enter} = 5'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_strobe(9'h17f);
    chk({24'h0, port_init}, {24'h0, PORT_INIT_VALUE});
    chk({30'h0, powerdown_flag, wdog_timeout_flag}, 32'h0);
    wait_release();
    foreach (rows[i]) begin
      if (rows[i].kind == 2'd3) begin
        @(posedge aclk);
        halt_enter <= 1'b1;
        cpu_halted <= 1'b1;
        @(posedge aclk);
        halt_enter <= 1'b0;
      end
      @(posedge aclk);
      case (rows[i].kind)
        2'd0: press <= 1'b1;
        2'd1: sag <= 1'b1;
        default: wdog_timeout <= 1'b1;
      endcase
      @(posedge aclk);
      wdog_timeout <= 1'b0;
      wait_strobe(rows[i].strb);
      if (rows[i].kind == 2'd1) chk({31'h0, supply_low_reset}, 32'h1);
      @(posedge aclk);
      press <= 1'b0;
      sag <= 1'b0;
      cpu_halted <= 1'b0;
      wait_release();
      chk({30'h0, powerdown_flag, wdog_timeout_flag}, {30'h0, rows[i].flags});
      axi_read(ADDR_STATUS, d, resp);
      chk({25'h0, d[6:4], 2'b0, d[1:0]}, {25'h0, rows[i].cause, 2'b0, rows[i].flags});
    end
    // short sag below the qualify time must pass unnoticed
    @(posedge aclk);
    sag <= 1'b1;
    repeat (15) @(posedge aclk);
    sag <= 1'b0;
    hit = 1'b0;
    repeat (40) begin @(posedge aclk); #1; hit = hit | core_hold; end
    chk({31'h0, hit}, 32'h0);
    axi_read(ADDR_CONFIG, d, resp);
    chk({25'h0, d[2:0], thr, lvd}, {25'h0, 3'h5, 2'h2, 2'h2});
    axi_write(8'h08, 32'h3, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_read(8'h0c, d, resp);
    chk(d, 32'h0);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(ADDR_STATUS, 32'h1, resp);
    chk({28'h0, resp, powerdown_flag, wdog_timeout_flag}, {28'h0, RESP_OKAY, 2'b10});
    // power-on arriving together with a pressed pin must still win
    @(posedge aclk);
    press <= 1'b1;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_strobe(9'h17f);
    chk({30'h0, powerdown_flag, wdog_timeout_flag}, 32'h0);
    @(posedge aclk);
    press <= 1'b0;
    wait_release();
    tally_and_finish();
  end
endmodule // mcu_reset_controller_bench

//--- tb/mrc_switch_model.sv
// far-side model: reset switch on a pulled-up pin, plus the supply monitor
`timescale 1ns/1ns
module mrc_switch_model (
  input wire logic press,
  input wire logic sag,
  output logic ext_reset_n,
  output logic supply_low
);
  // pull-up brings the pin back high as soon as the switch opens
  assign ext_reset_n = !press;
  // monitor level only; the device does the qualifying
  assign supply_low = sag;
endmodule // mrc_switch_model
